//--- logic/spac_pkg.sv
package spac_pkg;
  // apb byte addresses
  localparam logic [7:0] ADDR_CON1L = 8'h00;
  localparam logic [7:0] ADDR_CON1H = 8'h04;
  localparam logic [7:0] ADDR_STATL = 8'h08;
  localparam logic [7:0] ADDR_BUFL = 8'h0C;
  localparam logic [7:0] ADDR_BUFH = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
  localparam logic [7:0] ADDR_SYS = 8'h20;
  // control one low fields
  localparam int BIT_ON = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_SDO_DIS = 12;
  localparam int BIT_W32 = 11;
  localparam int BIT_W16 = 10;
  localparam int BIT_CKE = 8;
  localparam int BIT_SLAVE_SELECT_ENABLE = 7;
  localparam int BIT_CKP = 6;
  localparam int BIT_MCLK = 2;
  localparam logic [15:0] CON1L_MASK = 16'hBFFF;
  // control one high fields
  localparam int BIT_AUDIO_PROTOCOL_ENABLE = 15;
  localparam int BIT_FRAMED_MODE_ENABLE = 13;
  localparam int BIT_FSPW = 11;
  localparam int BIT_DSP = 0;
  localparam logic [15:0] CON1H_MASK = 16'hA801;
  // status low fields
  localparam int BIT_ROV = 6;
  localparam int BIT_RXF = 0;
  localparam int BIT_BUSY = 1;
  // interrupt events
  localparam int EV_DONE = 0;
  localparam int EV_ROV = 1;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [4:0] FRAME_BITS_16 = 5'h0F;
  localparam logic [4:0] FRAME_BITS_32 = 5'h1F;

  typedef struct packed {
    logic clk;
    logic din;
    logic ss_n;
  } spac_pins_in_type;

  typedef struct packed {
    logic dout;
    logic dout_oe;
    logic left_right_clock;
    logic rx_done;
  } spac_link_out_type;
endpackage

//--- logic/spac_link.sv
`timescale 1ns/10ps
module spac_link
  import spac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic start,
  input wire logic [31:0] tx_word,
  input wire logic wide,
  input wire logic cke,
  input wire logic ckp,
  input wire logic use_ss,
  input wire logic fs_pulse,
  input wire logic dsp,
  input wire logic sdo_dis,
  input wire spac_pins_in_type pins,
  output spac_link_out_type lout,
  output logic [31:0] rx_word,
  output logic busy
);
  typedef struct packed {
    logic [2:0] clk_s;
    logic [1:0] din_s;
    logic [1:0] ss_s;
    logic active;
    logic [4:0] cnt;
    logic [31:0] sh_tx;
    logic [31:0] sh_rx;
    logic [31:0] rx;
    logic done;
    logic dout;
    logic left_right_clock;
  } spac_link_state_type;
  spac_link_state_type st, next_st;
  logic rise, fall, shift_edge, samp_edge, ss_ok;

  always_comb begin
    next_st = st;
    next_st.clk_s = {st.clk_s[1:0], pins.clk};
    next_st.din_s = {st.din_s[0], pins.din};
    next_st.ss_s = {st.ss_s[0], pins.ss_n};
    next_st.done = 1'b0;
    rise = st.clk_s[1] & ~st.clk_s[2];
    fall = ~st.clk_s[1] & st.clk_s[2];
    shift_edge = (cke ^ ckp) ? rise : fall;
    samp_edge = (cke ^ ckp) ? fall : rise;
    ss_ok = ~use_ss | ~st.ss_s[1];
    if (!run) begin
      next_st.active = 1'b0;
      next_st.cnt = 5'h00;
    end else if (start && !st.active) begin
      next_st.active = 1'b1;
      next_st.sh_tx = tx_word;
      next_st.cnt = wide ? FRAME_BITS_32 : FRAME_BITS_16;
      next_st.dout = wide ? tx_word[31] : tx_word[15];
    end else if (st.active && ss_ok) begin
      if (samp_edge) begin
        next_st.sh_rx = {st.sh_rx[30:0], st.din_s[1]};
      end
      if (shift_edge) begin
        next_st.sh_tx = {st.sh_tx[30:0], 1'b0};
        next_st.dout = wide ? st.sh_tx[30] : st.sh_tx[14];
        if (st.cnt == 5'h00) begin
          next_st.active = 1'b0;
          next_st.done = 1'b1;
          next_st.rx = st.sh_rx;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
    end
    if (dsp) begin
      next_st.left_right_clock = next_st.active & (fs_pulse | (next_st.cnt ==
                    (wide ? FRAME_BITS_32 : FRAME_BITS_16)));
    end else begin
      next_st.left_right_clock = next_st.active;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lout.dout = st.dout;
  assign lout.dout_oe = ~sdo_dis & run;
  assign lout.left_right_clock = st.left_right_clock;
  assign lout.rx_done = st.done;
  assign rx_word = st.rx;
  assign busy = st.active;
endmodule

//--- logic/spac_top.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
// Functional notes
// - audio transfer starts once both buffers written, or low buffer alone at 16 bits
// - on bit off resets, stops, no events
// - idle halt bit stops module in idle
// - serial out disable releases data pin
// - audio mode forces clock edge select zero
// - framed mode ignores slave select enable
// - master clock select writable only when off
// - dsp mode ignores word widths, lrc follows pulse
module spac_top
  import spac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  input wire logic link_clk,
  input wire logic link_din,
  input wire logic link_ss_n,
  output logic link_dout,
  output logic link_dout_oe,
  output logic link_lrc,
  output logic irq
);
  typedef struct packed {
    logic [15:0] con1l;
    logic [15:0] con1h;
    logic [15:0] bufl;
    logic [15:0] bufh;
    logic wl;
    logic wh;
    logic rov;
    logic rxf;
    logic [31:0] rxd;
    logic [1:0] ists;
    logic [1:0] ien;
    logic [1:0] idle_s;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic dout;
    logic dout_oe;
    logic left_right_clock;
  } spac_state_type;
  spac_state_type st, next_st;
  spac_link_out_type lout;
  logic [31:0] rx_word;
  logic busy, run, audio, framed, wide, cke_eff, start, wr, rd, setup;
  spac_pins_in_type pins;

  function automatic logic [31:0] zext(input logic [15:0] v);
    zext = {16'h0000, v};
  endfunction

  // refused address or direction, answered with pslverr alongside pready
  function automatic logic addr_bad(input logic [7:0] a, input logic w);
    addr_bad = 1'b0;
    unique case (a)
      ADDR_CON1L, ADDR_CON1H, ADDR_STATL, ADDR_BUFL, ADDR_BUFH, ADDR_IRQ_EN: addr_bad = 1'b0;
      ADDR_IRQ_STAT, ADDR_SYS: addr_bad = w;
      ADDR_IRQ_CLR: addr_bad = ~w;
      default: addr_bad = 1'b1;
    endcase
  endfunction

  assign pins = '{clk: link_clk, din: link_din, ss_n: link_ss_n};
  assign audio = st.con1h[BIT_AUDIO_PROTOCOL_ENABLE];
  assign framed = st.con1h[BIT_FRAMED_MODE_ENABLE];
  assign run = st.con1l[BIT_ON] & ~(st.con1l[BIT_IDLE_HALT] & st.idle_s[1]);
  assign cke_eff = audio ? 1'b0 : st.con1l[BIT_CKE];
  assign wide = (audio & st.con1h[BIT_DSP]) ? 1'b1 : st.con1l[BIT_W32];
  assign start = run & st.wl & st.wh;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & st.ready;
  assign rd = setup & ~pwrite;

  spac_link u_link (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(run),
    .start(start),
    .tx_word({st.bufh, st.bufl}),
    .wide(wide),
    .cke(cke_eff),
    .ckp(st.con1l[BIT_CKP]),
    .use_ss(st.con1l[BIT_SLAVE_SELECT_ENABLE] & ~framed),
    .fs_pulse(st.con1h[BIT_FSPW]),
    .dsp(audio & st.con1h[BIT_DSP]),
    .sdo_dis(st.con1l[BIT_SDO_DIS]),
    .pins(pins),
    .lout(lout),
    .rx_word(rx_word),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.idle_s = {st.idle_s[0], cpu_idle};
    next_st.ready = setup;
    next_st.err = setup & addr_bad(paddr, pwrite);
    if (start) begin
      next_st.wl = 1'b0;
      next_st.wh = 1'b0;
    end
    if (wr) begin
      unique case (paddr)
        ADDR_CON1L: begin
          next_st.con1l = pwdata[15:0] & CON1L_MASK;
          if (st.con1l[BIT_ON]) begin
            next_st.con1l[BIT_MCLK] = st.con1l[BIT_MCLK];
          end
        end
        ADDR_CON1H: next_st.con1h = pwdata[15:0] & CON1H_MASK;
        ADDR_STATL: begin
          if (!pwdata[BIT_ROV]) begin
            next_st.rov = 1'b0;
          end
        end
        ADDR_BUFL: begin
          next_st.bufl = pwdata[15:0];
          next_st.wl = 1'b1;
          if (!wide) begin
            next_st.wh = 1'b1;
          end
        end
        ADDR_BUFH: begin
          next_st.bufh = pwdata[15:0];
          next_st.wh = 1'b1;
        end
        ADDR_IRQ_EN: next_st.ien = pwdata[1:0];
        ADDR_IRQ_CLR: next_st.ists = st.ists & ~pwdata[1:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        ADDR_CON1L: next_st.rdata = zext(st.con1l);
        ADDR_CON1H: next_st.rdata = zext(st.con1h);
        ADDR_STATL: next_st.rdata = zext({9'h000, st.rov, 4'h0, busy, st.rxf});
        ADDR_BUFL: next_st.rdata = zext(st.rxd[15:0]);
        ADDR_BUFH: next_st.rdata = zext(st.rxd[31:16]);
        ADDR_IRQ_STAT: next_st.rdata = {30'h00000000, st.ists};
        ADDR_IRQ_EN: next_st.rdata = {30'h00000000, st.ien};
        ADDR_SYS: next_st.rdata = {30'h00000000, run, audio};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    if (psel && penable && !pwrite && st.ready) begin
      if (paddr == ADDR_BUFL) begin
        next_st.rxf = 1'b0;
      end
    end
    if (lout.rx_done) begin
      next_st.rxd = rx_word;
      if (st.rxf) begin
        next_st.rov = 1'b1;
        next_st.ists[EV_ROV] = 1'b1;
      end
      next_st.rxf = 1'b1;
      next_st.ists[EV_DONE] = 1'b1;
    end
    if (!st.con1l[BIT_ON]) begin
      next_st.wl = 1'b0;
      next_st.wh = 1'b0;
      next_st.rxf = 1'b0;
      next_st.ists = 2'h0;
    end
    next_st.irq = |(next_st.ists & next_st.ien);
    next_st.dout = lout.dout;
    next_st.dout_oe = lout.dout_oe;
    next_st.left_right_clock = lout.left_right_clock;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign irq = st.irq;
  assign link_dout = st.dout;
  assign link_dout_oe = st.dout_oe;
  assign link_lrc = st.left_right_clock;

  ////////////////////////////////////////////////////////////////////////////
  a_off_no_irq: assert property (@(posedge sys_clk) disable iff (rst)
    !st.con1l[BIT_ON] |=> !irq) else $error("irq while off");
  a_sdo_release: assert property (@(posedge sys_clk) disable iff (rst)
    st.con1l[BIT_SDO_DIS] |-> ##2 !link_dout_oe) else $error("sdo driven");
  a_mclk_lock: assert property (@(posedge sys_clk) disable iff (rst)
    st.con1l[BIT_ON] |=> $stable(st.con1l[BIT_MCLK])) else $error("mclk changed");
  a_idle_halt: assert property (@(posedge sys_clk) disable iff (rst)
    (st.con1l[BIT_IDLE_HALT] && st.idle_s[1]) |=> !busy) else $error("no halt");
  a_idle_run: assert property (@(posedge sys_clk) disable iff (rst)
    (st.con1l[BIT_ON] && !st.con1l[BIT_IDLE_HALT] && busy) |=> (busy || lout.rx_done))
    else $error("halted");
  a_start_buf: assert property (@(posedge sys_clk) disable iff (rst)
    (start && !busy) |=> busy) else $error("no start");
  a_audio_cke: assert property (@(posedge sys_clk) disable iff (rst)
    audio |-> (u_link.shift_edge == (st.con1l[BIT_CKP] ? u_link.rise : u_link.fall)))
    else $error("cke not forced");
  a_frame_ss: assert property (@(posedge sys_clk) disable iff (rst)
    framed |-> u_link.ss_ok) else $error("ss used");
  a_dsp_wide: assert property (@(posedge sys_clk) disable iff (rst)
    (audio && st.con1h[BIT_DSP] && start && !busy) |=> (u_link.st.cnt == FRAME_BITS_32))
    else $error("width used");
  a_off_link: assert property (@(posedge sys_clk) disable iff (rst)
    !run |=> (!busy && !link_dout_oe)) else $error("link runs while stopped");
  a_halt_no_done: assert property (@(posedge sys_clk) disable iff (rst)
    !run |=> !lout.rx_done) else $error("event while stopped");
  a_sdo_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (run && !st.con1l[BIT_SDO_DIS]) |=> link_dout_oe) else $error("sdo not driven");
  a_mclk_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && paddr == ADDR_CON1L && !st.con1l[BIT_ON] && pwdata[BIT_MCLK])
    |=> st.con1l[BIT_MCLK]) else $error("mclk write lost");
  a_done_status: assert property (@(posedge sys_clk) disable iff (rst)
    (lout.rx_done && st.con1l[BIT_ON]) |=> (st.rxf && st.ists[EV_DONE]))
    else $error("done not flagged");
  a_irq_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && paddr == ADDR_IRQ_CLR && pwdata[EV_DONE] && !lout.rx_done)
    |=> !st.ists[EV_DONE]) else $error("status not cleared");
  a_ready_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    (psel && !penable) |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (@(posedge sys_clk) disable iff (rst)
    pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (@(posedge sys_clk) disable iff (rst)
    pslverr |-> pready) else $error("error without ready");
  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
  c_start: cover property (@(posedge sys_clk) disable iff (rst) start && !busy);
  c_dsp: cover property (@(posedge sys_clk) disable iff (rst)
    audio && st.con1h[BIT_DSP] && start);
  c_done: cover property (@(posedge sys_clk) disable iff (rst) lout.rx_done);
  c_rov: cover property (@(posedge sys_clk) disable iff (rst) $rose(st.rov));
  c_irq: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
endmodule

//--- bench/spac_codec.sv
`timescale 1ns/10ps
module spac_codec (
  output logic link_clk,
  output logic link_din,
  output logic link_ss_n,
  input wire logic link_dout,
  input wire logic link_dout_oe
);
  logic [31:0] cap;
  logic [15:0] pat;
  initial begin
    link_clk = 1'b0;
    link_din = 1'b1;
    link_ss_n = 1'b1;
    cap = 32'h00000000;
    pat = 16'h3C5A;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame of bits, clock stands still outside it, data sampled on the rise
  task frame(input logic ss_hold, input int bits);
    int i;
    cap = 32'h00000000;
    link_ss_n = ss_hold;
    #64;
    for (i = bits - 1; i >= 0; i--) begin
      link_din = pat[i[3:0]];
      #32 link_clk = 1'b1;
      cap = {cap[30:0], link_dout_oe ? link_dout : 1'bx};
      #32 link_clk = 1'b0;
    end
    link_ss_n = 1'b1;
    link_din = ~link_din;
  endtask
endmodule

//--- bench/spac_tb_top.sv
`timescale 1ns/10ps
module spac_tb_top import spac_pkg::*;;
  logic sys_clk, rst, psel, penable, pwrite, cpu_idle, oe_seen, err, lrc_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, link_clk, link_din, link_ss_n, link_dout, link_dout_oe, link_lrc, irq;
  int failures, checks_done, cyc;
  spac_top DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(cpu_idle), .link_clk(link_clk), .link_din(link_din),
    .link_ss_n(link_ss_n), .link_dout(link_dout), .link_dout_oe(link_dout_oe),
    .link_lrc(link_lrc), .irq(irq));
  spac_codec codec (.link_clk(link_clk), .link_din(link_din), .link_ss_n(link_ss_n),
    .link_dout(link_dout), .link_dout_oe(link_dout_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (link_dout_oe === 1'b1) oe_seen <= 1'b1;
    if (link_lrc === 1'b1) lrc_seen <= 1'b1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // setup, then access held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // configure, clear overflow, enable, load both buffer halves, run one frame
  task run(input logic [15:0] h, input logic [15:0] l, input logic ssh, input logic idl,
           input int nb);
    apb(1'b1, ADDR_CON1L, 32'h00000000);
    apb(1'b1, ADDR_BUFL, 32'h00000000);
    apb(1'b1, ADDR_BUFH, 32'h00000000);
    apb(1'b1, ADDR_IRQ_CLR, 32'h00000003);
    apb(1'b1, ADDR_CON1H, {16'h0000, h});
    apb(1'b1, ADDR_STATL, 32'h00000000);
    apb(1'b1, ADDR_IRQ_EN, 32'h00000001);
    apb(1'b1, ADDR_CON1L, {16'h0000, l});
    cpu_idle <= idl;
    oe_seen <= 1'b0;
    lrc_seen <= 1'b0;
    apb(1'b1, ADDR_BUFL, 32'h0000A53C);
    apb(1'b1, ADDR_BUFH, 32'h00005AC3);
    codec.frame(ssh, nb);
    repeat (30) @(posedge sys_clk);
    apb(1'b0, ADDR_IRQ_STAT, 32'h00000000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, penable, pwrite, cpu_idle, oe_seen} = 6'h21;
    lrc_seen = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CON1L, 32'h00000000);
    chk("con1l_reset", 32'h00000000, q);
    apb(1'b0, 8'h24, 32'h00000000);
    chk("unmapped_err", 32'h00000001, err);
    apb(1'b1, ADDR_CON1L, 32'h00000004);
    apb(1'b0, ADDR_CON1L, 32'h00000000);
    chk("mclk_off", 32'h00000004, q);
    apb(1'b1, ADDR_CON1L, 32'h00008004);
    apb(1'b1, ADDR_CON1L, 32'h00008000);
    apb(1'b0, ADDR_CON1L, 32'h00000000);
    chk("mclk_on", 32'h00008004, q);
    run(16'h8000, 16'h8100, 1'b0, 1'b0, 16);
    chk("tx_word", 32'h0000A53C, codec.cap);
    chk("oe_used", 32'h00000001, oe_seen);
    chk("lrc_used", 32'h00000001, lrc_seen);
    chk("done", 32'h00000001, q & 32'h1);
    apb(1'b0, ADDR_STATL, 32'h00000000);
    chk("rx_full", 32'h00000001, q & 32'h1);
    apb(1'b0, ADDR_BUFL, 32'h00000000);
    chk("rx_word", 32'h00003C5A, q);
    apb(1'b0, ADDR_SYS, 32'h00000000);
    chk("sys_run", 32'h00000003, q);
    settle();
    chk("irq_set", 32'h00000001, irq);
    apb(1'b1, ADDR_IRQ_EN, 32'h00000000);
    settle();
    chk("irq_masked", 32'h00000000, irq);
    apb(1'b1, ADDR_IRQ_EN, 32'h00000001);
    settle();
    chk("irq_unmasked", 32'h00000001, irq);
    apb(1'b1, ADDR_IRQ_CLR, 32'h00000001);
    settle();
    chk("irq_cleared", 32'h00000000, irq);
    apb(1'b0, ADDR_IRQ_STAT, 32'h00000000);
    chk("stat_cleared", 32'h00000000, q);
    run(16'h8000, 16'h9000, 1'b0, 1'b0, 16);
    chk("oe_released", 32'h00000000, oe_seen);
    run(16'hA000, 16'h8080, 1'b1, 1'b0, 16);
    chk("framed_no_ss", 32'h00000001, q & 32'h1);
    run(16'h8000, 16'hA000, 1'b0, 1'b1, 16);
    chk("idle_halted", 32'h00000000, q & 32'h1);
    run(16'h8000, 16'h8000, 1'b0, 1'b1, 16);
    chk("idle_running", 32'h00000001, q & 32'h1);
    run(16'h8001, 16'h8000, 1'b0, 1'b0, 32);
    chk("dsp_word", 32'h5AC3A53C, codec.cap);
    chk("lrc_pulse", 32'h00000001, lrc_seen);
    apb(1'b0, ADDR_BUFH, 32'h00000000);
    chk("rx_high", 32'h00003C5A, q);
    run(16'h8000, 16'h0000, 1'b0, 1'b0, 16);
    chk("off_no_event", 32'h00000000, q & 32'h1);
    chk("off_no_drive", 32'h00000000, oe_seen);
    cpu_idle <= 1'b0;
    finish_test();
  end
endmodule
